// ===== dma_trigger_select_overflow.sv
// Purpose: trigger source select, pending flag and overflow detect of one channel
// Assumes: event inputs are pins, synchronised here; one 200 MHz clock
// Notes: status is read-to-clear; a new set wins over the clear
// Contract
// - overflow interrupt only when enable bit set
// - overflow: new trigger while pending flag set
// - pending flag holds until channel serviced
// - five-bit selector picks burst trigger source
// - only the selected source is accepted
// - sync routed only for first converter source
// - trigger enable low blocks events and software
// - routed sync honoured only with sync enable
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module dma_trigger_select_overflow
    import trig_sel_pkg::*;
(
    input wire logic clock, // 200 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [ADDR_W-1:0] addr, // register index
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [15:0] rdata, // read data, cycle after rd
    input wire logic converter_seq_a_event, // first sequencer event pin
    input wire logic converter_seq_b_event, // second sequencer event pin
    input wire logic ext_event_line_1, // external line 1
    input wire logic ext_event_line_2, // external line 2
    input wire logic ext_event_line_3, // external line 3
    input wire logic ext_event_line_4, // external line 4
    input wire logic ext_event_line_5, // external line 5
    input wire logic ext_event_line_6, // external line 6
    input wire logic ext_event_line_7, // external line 7
    input wire logic ext_event_line_13, // external line 13
    input wire logic converter_sync_signal, // converter sync pin
    input wire logic serviced, // engine has serviced pending trigger
    output logic trigger_pending_flag, // latched trigger awaiting service
    output logic sync_event, // one-cycle routed sync pulse
    output logic irq // level interrupt
);
    // ****************************************
    // reset release
    // ****************************************
    // the pin may rise at any point of the cycle; release through two
    // flops so every register leaves reset on the same clean edge
    logic rst_s1_q, rst_s1_d;
    logic rst_s2_q, rst_s2_d;
    logic rst_i_n;
    always_comb begin
        rst_s1_d = 1'b1;
        rst_s2_d = rst_s1_q;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= rst_s1_d;
            rst_s2_q <= rst_s2_d;
        end
    end
    assign rst_i_n = rst_s2_q;

    // ****************************************
    // event pin synchronisers
    // ****************************************
    localparam int PIN_N = 11;
    localparam int PIN_SEQ_A = 0;
    localparam int PIN_SEQ_B = 1;
    localparam int PIN_EXT_BASE = 2;
    localparam int PIN_SYNC = 10;
    logic [PIN_N-1:0] pins;
    assign pins = {converter_sync_signal, ext_event_line_13, ext_event_line_7,
                   ext_event_line_6, ext_event_line_5, ext_event_line_4,
                   ext_event_line_3, ext_event_line_2, ext_event_line_1,
                   converter_seq_b_event, converter_seq_a_event};
    // two flops against metastability; the third only keeps the last
    // settled level for the edge detector
    // limitation: a pin must stay low one cycle between events
    logic [PIN_N-1:0] s1_q, s1_d;
    logic [PIN_N-1:0] s2_q, s2_d;
    logic [PIN_N-1:0] s3_q, s3_d;
    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end
    // flops clear to the idle pin level, so no false edge after reset
    logic [PIN_N-1:0] rise;
    assign rise = s2_q & ~s3_q;

    // ****************************************
    // decode helpers
    // ****************************************
    // one access of the given kind at the given register index
    function automatic logic reg_hit(
        input logic strobe,
        input logic [ADDR_W-1:0] index,
        input logic [ADDR_W-1:0] ofs
    );
        return strobe && (index == ofs);
    endfunction

    // external codes map in order onto the external pins
    function automatic logic ext_pick(
        input logic [SEL_W-1:0] code,
        input logic [PIN_N-1:0] edges
    );
        logic [2:0] slot;
        slot = 3'(code - SRC_EXT_FIRST);
        return edges[PIN_EXT_BASE + int'(slot)];
    endfunction

    // ****************************************
    // mode fields and access decode
    // ****************************************
    logic [SEL_W-1:0] sel;
    logic trig_en;
    logic sync_en;
    logic ovr_ie;
    logic wr_mode;
    logic wr_mask;
    logic wr_ctrl;
    logic rd_status;
    logic [15:0] mode_q, mode_d;
    assign sel = mode_q[POS_SEL +: SEL_W];
    assign trig_en = mode_q[POS_TRIG_EN];
    assign sync_en = mode_q[POS_SYNC_EN];
    assign ovr_ie = mode_q[POS_OVR_IE];
    assign wr_mode = reg_hit(wr, addr, OFS_MODE);
    assign wr_mask = reg_hit(wr, addr, OFS_MASK);
    assign wr_ctrl = reg_hit(wr, addr, OFS_CTRL);
    assign rd_status = reg_hit(rd, addr, OFS_STATUS);

    // ****************************************
    // mode register
    // ****************************************
    // reserved bits are never stored, so they always read back as zero
    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = wdata & MODE_WMASK;
        end
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            mode_q <= MODE_RST;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ****************************************
    // interrupt mask
    // ****************************************
    // bits line up with the status bits
    logic [2:0] mask_q, mask_d;
    always_comb begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = wdata[2:0];
        end
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            mask_q <= IRQ_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ****************************************
    // trigger selection
    // ****************************************
    logic sel_event;
    logic sw_req;
    logic svc_wr;
    logic trig;
    logic ovr;
    logic sync_hit;
    logic pend_q, pend_d;
    always_comb begin
        sel_event = 1'b0;
        unique case (sel)
            SRC_NONE: sel_event = 1'b0;
            SRC_SEQ_A: sel_event = rise[PIN_SEQ_A];
            SRC_SEQ_B: sel_event = rise[PIN_SEQ_B];
            default: begin
                // codes beyond the external range stand for sources not built here
                if (sel >= SRC_EXT_FIRST && sel <= SRC_EXT_LAST) begin
                    sel_event = ext_pick(sel, rise);
                end
            end
        endcase
    end
    assign sw_req = wr_ctrl && wdata[POS_CTRL_SWREQ];
    assign svc_wr = wr_ctrl && wdata[POS_CTRL_SERVICED];
    // software requests pass the same enable as pin events
    assign trig = trig_en && (sel_event || sw_req);
    assign ovr = trig && pend_q;
    assign sync_hit = (sel == SRC_SEQ_A) && sync_en && rise[PIN_SYNC];

    // ****************************************
    // trigger pending flag
    // ****************************************
    always_comb begin
        pend_d = pend_q;
        if (serviced || svc_wr) begin
            pend_d = 1'b0;
        end
        // a fresh trigger wins over the clear; an overflow only keeps
        // the flag, so at most one unserviced trigger is ever held
        if (trig) begin
            pend_d = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // ****************************************
    // sticky status, cleared by a read
    // ****************************************
    logic [2:0] status_q, status_d;
    always_comb begin
        status_d = status_q;
        if (rd_status) begin
            status_d = IRQ_RST;
        end
        // sets come after the clear so an event in the reading cycle survives
        if (ovr && ovr_ie) begin
            status_d[POS_ST_OVR] = 1'b1;
        end
        if (trig) begin
            status_d[POS_ST_TRIG] = 1'b1;
        end
        if (sync_hit) begin
            status_d[POS_ST_SYNC] = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            status_q <= IRQ_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // ****************************************
    // read data, valid only in the cycle after the strobe
    // ****************************************
    logic [15:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = 16'h0000;
        if (rd) begin
            unique case (addr)
                OFS_MODE: rdata_d = mode_q;
                OFS_STATUS: rdata_d = {13'h0000, status_q};
                OFS_MASK: rdata_d = {13'h0000, mask_q};
                OFS_CTRL: rdata_d = {14'h0000, pend_q, 1'b0};
                default: rdata_d = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // routed sync pulse
    // ****************************************
    // one cycle after the hit, in step with the status bit it sets
    logic sync_q, sync_d;
    always_comb begin
        sync_d = sync_hit;
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // irq follows registered status and mask only, no bus path reaches it
    assign rdata = rdata_q;
    assign trigger_pending_flag = pend_q;
    assign sync_event = sync_q;
    assign irq = |(status_q & mask_q);
endmodule

// ===== trig_sel_pkg.sv
// Purpose: constants for the channel trigger select and overflow block
// Assumes: 16-bit register data on a plain strobe port
// Notes: offsets are word indices on the local register port
package trig_sel_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_MASK = 4'h2;
    localparam logic [3:0] OFS_CTRL = 4'h3;
    localparam int POS_SEL = 0;
    localparam int SEL_W = 5;
    localparam int POS_OVR_IE = 7;
    localparam int POS_TRIG_EN = 8;
    localparam int POS_SYNC_EN = 12;
    localparam logic [15:0] MODE_WMASK = 16'hff9f;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [4:0] SRC_NONE = 5'h00;
    localparam logic [4:0] SRC_SEQ_A = 5'h01;
    localparam logic [4:0] SRC_SEQ_B = 5'h02;
    localparam logic [4:0] SRC_EXT_FIRST = 5'h03;
    localparam logic [4:0] SRC_EXT_LAST = 5'h0a;
    localparam int POS_ST_OVR = 0;
    localparam int POS_ST_TRIG = 1;
    localparam int POS_ST_SYNC = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam int POS_CTRL_SWREQ = 0;
    localparam int POS_CTRL_SERVICED = 1;
endpackage

// ===== trig_sel_checker.sv
// Purpose: concurrent checks on the channel's ports
// Assumes: one clock, asynchronous active-low reset
// Notes: bound by name into the design module
`timescale 1ns/10ps
module trig_sel_checker
    import trig_sel_pkg::*;
(
    input wire logic clock, // clock
    input wire logic rst_n, // reset
    input wire logic [ADDR_W-1:0] addr, // index
    input wire logic [15:0] wdata, // data
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [15:0] rdata, // read data
    input wire logic serviced, // service
    input wire logic trigger_pending_flag, // pending
    input wire logic sync_event, // sync
    input wire logic irq // interrupt
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence mask_off;
        wr && addr == OFS_MASK && wdata[2:0] == 3'h0;
    endsequence
    chk_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
        else $error("rdata not idle");
    chk_unmapped_zero: assert property (rd && addr > OFS_CTRL |=> rdata == 16'h0000)
        else $error("unmapped read");
    chk_mode_reserved: assert property (rd && addr == OFS_MODE |=> rdata[6:5] == 2'b00)
        else $error("reserved bits");
    chk_ctrl_pending: assert property (rd && addr == OFS_CTRL |=> rdata[1] == $past(trigger_pending_flag))
        else $error("pending read");
    chk_flag_holds: assert property (trigger_pending_flag && !serviced
        && !(wr && addr == OFS_CTRL && wdata[1]) |=> trigger_pending_flag) else $error("flag lost");
    chk_flag_fall: assert property ($fell(trigger_pending_flag)
        |-> $past(serviced || (wr && addr == OFS_CTRL && wdata[1]))) else $error("flag fell");
    chk_sync_single: assert property (sync_event |=> !sync_event)
        else $error("sync pulse long");
    chk_irq_masked: assert property (mask_off |-> ##2 !irq)
        else $error("masked irq");
endmodule
bind dma_trigger_select_overflow trig_sel_checker chk_u (.*);

// ===== event_src_model.sv
// Purpose: event source pins at the channel's far side
// Assumes: the bench raises fire for one cycle per event
// Notes: no reset; pins idle low
`timescale 1ns/10ps
module event_src_model (
    input wire logic clock, // clock
    input wire logic [10:0] fire, // lines to raise
    output logic [10:0] pins // event pins
);
    logic [1:0] left = '0;
    initial pins = '0;
    // three cycles high so the two-flop synchroniser sees every edge
    always @(posedge clock) begin
        left <= (|fire) ? 2'h2 : left - {1'b0, left != 2'h0};
        if (|fire) pins <= fire;
        else if (left == 2'h0) pins <= '0;
    end
endmodule

// ===== tb_top.sv
// Purpose: bench for the trigger select and overflow block
// Assumes: pins 0-9 are codes 1-10, pin 10 is the sync line
// Notes: mask keeps overflow only
`timescale 1ns/10ps
module tb_top
    import trig_sel_pkg::*;
;
    logic clock = 0, rst_n = 0, wr = 0, rd = 0, serviced = 0, rd_d = 0;
    logic trigger_pending_flag, sync_event, irq;
    logic [3:0] addr = '0;
    logic [15:0] wdata = '0, rdata;
    logic [10:0] fire = '0, pins;
    logic [31:0] rnd = 32'h8209;
    logic [15:0] exp_q[$];
    int err_count = 0, checked = 0, cyc = 0, sync_cnt = 0;
    dma_trigger_select_overflow dut_u (.*, .converter_seq_a_event(pins[0]),
        .converter_seq_b_event(pins[1]), .ext_event_line_1(pins[2]), .ext_event_line_2(pins[3]),
        .ext_event_line_3(pins[4]), .ext_event_line_4(pins[5]), .ext_event_line_5(pins[6]),
        .ext_event_line_6(pins[7]), .ext_event_line_7(pins[8]), .ext_event_line_13(pins[9]),
        .converter_sync_signal(pins[10]));
    event_src_model src_u (.*);
    initial begin
        forever #2.5 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] want);
        checked++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic chk1(input logic got, input logic want);
        checked++;
        if (got !== want) begin
            err_count++;
            $display("Error at %0t: level %b want %b", $time, got, want);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (rd_d) chk16(rdata, exp_q.pop_front());
        if (sync_event) sync_cnt++;
        rd_d <= rd;
        if (cyc > 9000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // n of zero means a software request instead of pin events
    task automatic trial(input logic [15:0] mode, input logic [10:0] src, input int n,
        input logic [2:0] st);
        sync_cnt = 0;
        bus(1, OFS_MODE, mode);
        if (n == 0) bus(1, OFS_CTRL, 16'h0001);
        repeat (n) begin
            fire <= src;
            @(posedge clock);
            fire <= '0;
            repeat (9) @(posedge clock);
        end
        repeat (4) @(posedge clock);
        chk1(irq, st[0]);
        chk1(trigger_pending_flag, st[1]);
        chk16(16'(sync_cnt), {15'h0000, st[2]});
        bus(0, OFS_STATUS, {13'h0000, st});
        bus(0, OFS_CTRL, {14'h0000, st[1], 1'b0});
        if (n == 0) begin
            bus(1, OFS_CTRL, 16'h0002);
        end else begin
            serviced <= 1'b1;
            @(posedge clock);
            serviced <= 1'b0;
        end
        @(posedge clock);
        chk1(trigger_pending_flag, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rnd = xs(rnd);
        bus(0, OFS_MODE, MODE_RST);
        bus(1, OFS_MODE, rnd[15:0]);
        bus(0, OFS_MODE, rnd[15:0] & MODE_WMASK);
        bus(1, {1'b1, rnd[18:16]}, rnd[31:16]);
        bus(0, {1'b1, rnd[18:16]}, 16'h0000);
        bus(1, OFS_MASK, 16'h0001);
        $display("registers done");
        for (int k = 0; k < 12; k++) begin
            for (int j = 0; j < 10; j++) begin
                trial({11'h00c, k > 10 ? 5'h1f : 5'(k)}, 11'h001 << j, 1,
                    (j + 1 == k) ? 3'b010 : 3'b000);
            end
        end
        $display("selection done");
        trial(16'h0183, 11'h004, 2, 3'b011);
        trial(16'h0103, 11'h004, 2, 3'b010);
        trial(16'h0001, 11'h001, 1, 3'b000);
        trial(16'h0003, 11'h000, 0, 3'b000);
        trial(16'h0103, 11'h000, 0, 3'b010);
        trial(16'h1101, 11'h400, 1, 3'b100);
        trial(16'h1102, 11'h400, 1, 3'b000);
        trial(16'h0101, 11'h400, 1, 3'b000);
        bus(1, OFS_MASK, 16'h0000);
        $display("events done");
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule
